// ---- ivm_pkg.sv ----
// package: register map, field layout and constants for the input path volume block
package ivm_pkg;
  // printed offsets are not multiples of four, so they are indices; byte address is index times four
  localparam logic [11:0] IVM_IDX_P2L = 12'h319;
  localparam logic [11:0] IVM_IDX_P2R = 12'h31D;
  localparam logic [11:0] IVM_IDX_P3L = 12'h321;
  localparam logic [13:0] IVM_ADDR_P2L = {IVM_IDX_P2L, 2'b00};
  localparam logic [13:0] IVM_ADDR_P2R = {IVM_IDX_P2R, 2'b00};
  localparam logic [13:0] IVM_ADDR_P3L = {IVM_IDX_P3L, 2'b00};
  localparam int IVM_NCH = 3;
  localparam int IVM_TRIG_BIT = 9;
  localparam int IVM_MUTE_BIT = 8;
  localparam int IVM_GAIN_MSB = 7;
  localparam logic IVM_MUTE_RST = 1'b1;
  localparam logic [7:0] IVM_GAIN_RST = 8'h80;
  localparam logic [7:0] IVM_GAIN_MAX = 8'hBF;
  // internal gain in eighth-dB units: code*4, so one half-dB code step is four fine steps
  localparam int IVM_FINE_PER_CODE = 4;
  localparam logic [9:0] IVM_FINE_RST = 10'h200;
  localparam int IVM_SAMPLE_W = 24;
  localparam int IVM_FIFO_DEPTH = 8;
endpackage

// ---- ivm_fifo.sv ----
// buffer: the fifo module sits beside the top module, so no design unit is declared here

// ---- ivm_top.sv ----
// top: apb registers, staged gain and mute, ramped gain and sample path
`timescale 1ns/1ps
// What this block does
// RL1: writing one to the trigger bit applies all pending gains and mutes together
// RL2: bit 8 per channel mutes; one silences, zero passes; resets muted
// RL3: eight-bit gain code, -64 dB to +31.5 dB in half-dB steps
// RL4: gain resets to 0x80, unity; each code step is half a dB
// RL5: software must not program reserved codes 0xC0 to 0xFF
// RL6: trigger bit is write-only and reads back as zero
// RL7: applied gain ramps internally in 0.125 dB steps
// RL8: gain and mute writes stay pending until the trigger fires
module ivm_top
  import ivm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [1:0] in_chan,
  input wire logic [IVM_SAMPLE_W-1:0] in_sample,
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_chan,
  output logic [IVM_SAMPLE_W-1:0] out_sample,
  output logic [IVM_NCH*10-1:0] applied_fine_gain,
  output logic [IVM_NCH-1:0] applied_silence
);
  localparam int FW = 2 + IVM_SAMPLE_W;

  // apb decode
  wire setup = psel && !penable;
  wire hit_p2l = (paddr[15:2] == {2'b00, IVM_IDX_P2L});
  wire hit_p2r = (paddr[15:2] == {2'b00, IVM_IDX_P2R});
  wire hit_p3l = (paddr[15:2] == {2'b00, IVM_IDX_P3L});
  wire [IVM_NCH-1:0] hit = {hit_p3l, hit_p2r, hit_p2l};
  wire mapped = |hit;
  // writes land at the edge where pready is seen, never in the setup cycle
  wire acc_phase = psel && penable && pready;
  wire wr_now = ce && acc_phase && pwrite && mapped;
  // RL1: trigger from any channel
  wire apply_now = wr_now && pwdata[IVM_TRIG_BIT];

  logic [7:0] pend_gain_q [IVM_NCH];
  logic [IVM_NCH-1:0] pend_mute_q;
  logic [9:0] fine_q [IVM_NCH];
  logic [9:0] target_q [IVM_NCH];
  logic [IVM_NCH-1:0] silence_q;

  // read mux: trigger bit always zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < IVM_NCH; i++)
      if (hit[i])
        // RL6: trigger reads as zero
        rd_mux = {22'h0, 1'b0, pend_mute_q[i], pend_gain_q[i]};
  end

  // no wait state: answer in the first access cycle following setup
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  genvar g;
  generate
    for (g = 0; g < IVM_NCH; g++)
    begin : g_ch
      // staged settings, written at the access edge
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          // RL2: muted at reset
          pend_mute_q[g] <= IVM_MUTE_RST;
          // RL4: unity gain at reset
          pend_gain_q[g] <= IVM_GAIN_RST;
        end
        else if (wr_now && hit[g])
        begin
          // RL8: held pending until trigger
          pend_mute_q[g] <= pwdata[IVM_MUTE_BIT];
          // RL3: eight-bit gain code
          pend_gain_q[g] <= pwdata[IVM_GAIN_MSB:0];
        end
      end

      // target for the ramp; a trigger write also carries its own channel's new value
      wire [7:0] new_gain = hit[g] ? pwdata[IVM_GAIN_MSB:0] : pend_gain_q[g];
      wire new_mute = hit[g] ? pwdata[IVM_MUTE_BIT] : pend_mute_q[g];
      // RL5: reserved codes are clamped to the top valid code, no garbage gain
      wire [7:0] safe_gain = (new_gain > IVM_GAIN_MAX) ? IVM_GAIN_MAX : new_gain;

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          target_q[g] <= IVM_FINE_RST;
          fine_q[g] <= IVM_FINE_RST;
          silence_q[g] <= IVM_MUTE_RST;
        end
        else if (ce)
        begin
          // RL1: all channels take effect same edge
          if (apply_now)
          begin
            target_q[g] <= {safe_gain, 2'b00};
            silence_q[g] <= new_mute;
          end
          // RL7: eighth-dB ramp steps
          if (fine_q[g] < target_q[g])
            fine_q[g] <= fine_q[g] + 10'd1;
          else if (fine_q[g] > target_q[g])
            fine_q[g] <= fine_q[g] - 10'd1;
        end
      end
    end
  endgenerate

  // sample path: scale by applied gain, zero when silenced
  wire [1:0] ch_sel = (in_chan < 2'(IVM_NCH)) ? in_chan : 2'd0;
  wire [9:0] cur_fine = fine_q[ch_sel];
  // coarse linear approximation: each 6 dB (48 fine) doubles; fraction ignored
  wire signed [10:0] rel = $signed({1'b0, cur_fine}) - $signed({1'b0, IVM_FINE_RST});
  wire signed [10:0] shamt = rel / 11'sd48;
  wire signed [IVM_SAMPLE_W-1:0] s_in = in_sample;
  wire signed [IVM_SAMPLE_W-1:0] scaled = (shamt >= 0) ? (s_in <<< shamt[4:0]) : (s_in >>> (-shamt));
  wire [IVM_SAMPLE_W-1:0] s_out = silence_q[ch_sel] ? '0 : scaled;

  logic fifo_in_ready;
  logic [FW-1:0] fifo_out;
  logic fifo_out_valid;
  assign in_ready = fifo_in_ready;

  ivm_fifo #(.WIDTH(FW), .DEPTH(IVM_FIFO_DEPTH)) u_fifo
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(in_valid),
    .in_ready(fifo_in_ready),
    .in_data({ch_sel, s_out}),
    .out_valid(fifo_out_valid),
    .out_ready(out_ready && !out_valid),
    .out_data(fifo_out)
  );

  // registered output stage, one word at a time
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_chan <= 2'd0;
      out_sample <= '0;
      applied_fine_gain <= {IVM_FINE_RST, IVM_FINE_RST, IVM_FINE_RST};
      applied_silence <= {IVM_NCH{IVM_MUTE_RST}};
    end
    else if (ce)
    begin
      applied_fine_gain <= {fine_q[2], fine_q[1], fine_q[0]};
      applied_silence <= silence_q;
      if (out_valid && out_ready)
        out_valid <= 1'b0;
      else if (!out_valid && fifo_out_valid && out_ready)
      begin
        out_valid <= 1'b1;
        out_chan <= fifo_out[FW-1:FW-2];
        out_sample <= fifo_out[IVM_SAMPLE_W-1:0];
      end
    end
  end
endmodule

// fifo: parameterised synchronous buffer with valid/ready on both sides
module ivm_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic rdy_q;
  wire push = ce && in_valid && in_ready;
  wire pop = ce && out_valid && out_ready;

  // ready is registered from the next count, so the top's in_ready is a flop output
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = rdy_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];

  // pointers wrap by power-of-two depth
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end

  // storage has no reset
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end
endmodule

// ---- ivm_sva.sv ----
// checker: apb timing, apply and ramp properties of the volume block
`timescale 1ns/1ps
module ivm_sva
  import ivm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic in_ready,
  input wire logic [IVM_NCH*10-1:0] applied_fine_gain,
  input wire logic [IVM_NCH-1:0] applied_silence
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // access edge carrying the apply bit
  wire trig = psel && penable && pready && pwrite && ce && pwdata[9];
  property p_rdy; psel && !penable && ce |=> pready; endproperty
  property p_pulse; pready && ce |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_rd; pready |-> prdata[31:9] == 23'h0; endproperty
  property p_sil; $changed(applied_silence) |-> $past(trig, 2); endproperty
  property p_step; (applied_fine_gain[9:0] - $past(applied_fine_gain[9:0])) inside {10'h0, 10'h1, 10'h3FF}; endproperty
  property p_max; applied_fine_gain[29:20] <= 10'h2FC; endproperty
  property p_init; $fell(rst) |-> applied_silence == 3'h7 && applied_fine_gain == {3{10'h200}}; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_rd: assert property (p_rd) else $error("upper read bits set");
  a_sil: assert property (p_sil) else $error("silence changed without apply");
  a_step: assert property (p_step) else $error("gain jumped");
  a_max: assert property (p_max) else $error("gain above top code");
  a_init: assert property (p_init) else $error("bad reset state");
  // main scenarios reached
  c_trig: cover property (trig);
  c_err: cover property (pslverr);
  c_full: cover property (!in_ready);
endmodule
bind ivm_top ivm_sva u_sva (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_ready(in_ready),
  .applied_fine_gain(applied_fine_gain), .applied_silence(applied_silence));

// ---- ivm_top_tb.sv ----
// testbench: register access, apply, ramp and stream checks for the volume block
`timescale 1ns/1ps
module ivm_top_tb;
  import ivm_pkg::*;
  localparam logic [15:0] A2L = 16'(IVM_ADDR_P2L);
  localparam logic [15:0] A2R = 16'(IVM_ADDR_P2R);
  localparam logic [15:0] A3L = 16'(IVM_ADDR_P3L);
  logic clk, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, in_valid = 1'b0, out_ready = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, in_ready, out_valid;
  logic [1:0] in_chan = 2'h0, out_chan;
  logic [IVM_SAMPLE_W-1:0] in_sample = 24'h0, out_sample;
  logic [29:0] applied_fine_gain;
  logic [2:0] applied_silence;
  int err_total = 0, compares = 0, n, i;
  ivm_top dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready),
    .in_chan(in_chan), .in_sample(in_sample), .out_valid(out_valid), .out_ready(out_ready), .out_chan(out_chan),
    .out_sample(out_sample), .applied_fine_gain(applied_fine_gain), .applied_silence(applied_silence));
  task summarize();
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    cmp(pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [15:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    cmp(r, x);
    cmp(e, xe);
  endtask
  // offer one word until the buffer takes it
  task push(input logic [1:0] c, input logic [23:0] s);
    @(posedge clk);
    in_valid <= 1'b1;
    in_chan <= c;
    in_sample <= s;
    do @(posedge clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // bounds a hang at ten thousand cycles; the run needs under a thousand cycles
  initial
  begin
    #100000;
    err_total++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(A2L, 32'h180, 1'b0);
    rdc(A2R, 32'h180, 1'b0);
    rdc(A3L, 32'h180, 1'b0);
    cmp(applied_fine_gain, {3{10'h200}});
    apb(1'b1, A2L, 32'h280);
    repeat (3) @(posedge clk);
    cmp(applied_silence, 3'h6);
    // fill while the far side stalls; path3 left is still muted
    for (i = 0; i < 8; i++)
      push(i[0] ? 2'h2 : 2'h0, {8'(i), 16'hA5C3});
    repeat (2) @(posedge clk);
    cmp(in_ready, 1'b0);
    out_ready <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        #1;
        n++;
      end
      while (out_valid !== 1'b1 && n < 50);
      cmp(out_valid, 1'b1);
      cmp(out_chan, i[0] ? 2'h2 : 2'h0);
      cmp(out_sample, i[0] ? 24'h0 : {8'(i), 16'hA5C3});
    end
    apb(1'b1, A3L, 32'h1A0);
    rdc(A3L, 32'h1A0, 1'b0);
    apb(1'b1, A2L, 32'h000);
    repeat (3) @(posedge clk);
    cmp(applied_silence, 3'h6);
    cmp(applied_fine_gain, {3{10'h200}});
    apb(1'b1, A2R, 32'h2BF);
    rdc(A2R, 32'h0BF, 1'b0);
    cmp(applied_silence, 3'h4);
    // freeze mid-ramp: nothing may move while the enable is low
    ce <= 1'b0;
    @(posedge clk);
    r = applied_fine_gain;
    repeat (3) @(posedge clk);
    cmp(applied_fine_gain, r);
    ce <= 1'b1;
    repeat (600) @(posedge clk);
    cmp(applied_fine_gain, {10'h280, 10'h2FC, 10'h000});
    rdc(16'h0010, 32'h0, 1'b1);
    summarize();
  end
endmodule
